/* File: dv/fgpm_host_model.sv */
// host processor model: deep-idle request, addressed wake, commands
`timescale 1ns/100ps
module fgpm_host_model (
	input wire logic clock, // system clock
	output logic addr_hit, // addressed transaction level
	output logic cmd_pending, // command waiting level
	output logic deep_idle_req // deep-idle request bit
);
	initial begin
		addr_hit = 1'b0;
		cmd_pending = 1'b0;
		deep_idle_req = 1'b0;
	end
	task automatic request_deep(input logic on);
		@(posedge clock);
		deep_idle_req <= on;
	endtask
	// levels stay until released: the pins pass a 2-stage synchroniser
	task automatic wake(input logic on);
		@(posedge clock);
		addr_hit <= on;
	endtask
	task automatic command(input logic on);
		@(posedge clock);
		cmd_pending <= on;
	endtask
endmodule

/* File: dv/fuel_gauge_power_modes_test.sv */
// self-checking bench for the power-mode sequencer
`timescale 1ns/100ps
module fuel_gauge_power_modes_test;
	import fgpm_pkg::*;
	logic clock = 1'b0, rst = 1'b1, cell_detect = 1'b0, ext_power = 1'b1;
	logic wake_cmp = 1'b0, sample_strobe = 1'b0, ocv_done = 1'b0;
	logic light_doze_allow = 1'b0, addr_hit, cmd_pending, deep_idle_req;
	logic [15:0] mean_current_value = 16'h0010, cell_voltage = 16'h0E00;
	logic [15:0] init_charge = 16'h0000, terminate_voltage = 16'h0B00;
	logic signed [15:0] charge_delta = 16'sh0000;
	logic [7:0] soc_estimate = 8'h00, operation_config = 8'h00;
	logic [15:0] low_charge_set_level, low_charge_clear_level;
	logic [15:0] doze_current_limit, deep_current_limit;
	logic [15:0] deep_voltage_limit = 16'h0C00;
	logic [2:0] power_mode;
	logic hf_osc_en, battery_present_flag, low_charge_flag, ocv_start;
	logic profile_select, cal_active, measure_strobe, cmd_service, ocv_valid;
	logic [15:0] remaining_charge_value, exp_rem, tgt;
	logic [7:0] soc_value, est;
	logic exp_low;
	int fail_count = 0, cmp_count = 0, cycles = 0, n;
	fgpm_top dut (.clock, .rst, .cell_detect, .ext_power, .wake_cmp,
		.addr_hit, .cmd_pending, .mean_current_value, .cell_voltage,
		.charge_delta, .sample_strobe, .init_charge, .soc_estimate,
		.ocv_done, .operation_config, .light_doze_allow, .deep_idle_req,
		.low_charge_set_level, .low_charge_clear_level,
		.doze_current_limit, .deep_current_limit, .deep_voltage_limit,
		.terminate_voltage, .power_mode, .hf_osc_en,
		.battery_present_flag, .low_charge_flag, .remaining_charge_value,
		.soc_value, .ocv_start, .profile_select, .cal_active,
		.measure_strobe, .cmd_service, .ocv_valid);
	fgpm_host_model host (.clock, .addr_hit, .cmd_pending, .deep_idle_req);
	always #12.5 clock = ~clock;
	////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	function automatic logic exp_flag(input logic prev, input logic [15:0] r);
		if (r < low_charge_set_level) return 1'b1;
		if (r > low_charge_clear_level) return 1'b0;
		return prev;
	endfunction
	function automatic logic [7:0] exp_soc(input logic [7:0] e,
		input logic [15:0] v, t);
		return (v <= t) ? SOC_EMPTY : e;
	endfunction
	////////////////////////////////////////////////////////////////////
	task automatic wait_mode(input fgpm_mode_t m, input int lim);
		int k;
		k = 0;
		@(negedge clock);
		while (power_mode !== m && k < lim) begin
			@(negedge clock);
			k++;
		end
		chk("power_mode", 16'(m), 16'(power_mode));
	endtask
	task automatic hold_mode(input fgpm_mode_t m, input int len);
		logic ok;
		ok = 1'b1;
		repeat (len) begin
			@(negedge clock);
			if (power_mode !== m) ok = 1'b0;
		end
		chk_bit("mode held", 1'b1, ok);
	endtask
	task automatic strobes(input int len, output int k);
		k = 0;
		repeat (len) begin
			@(negedge clock);
			if (measure_strobe === 1'b1) k++;
		end
	endtask
	task automatic bring_up();
		wait_mode(FGPM_INIT, 10);
		chk_bit("ocv_start", 1'b1, ocv_start);
		@(posedge clock);
		ocv_done <= 1'b1;
		@(posedge clock);
		ocv_done <= 1'b0;
		wait_mode(FGPM_NORMAL, 10);
		chk_bit("profile_select", 1'b1, profile_select);
		chk_bit("present", 1'b1, battery_present_flag);
	endtask
	task automatic exit_by(input int c);
		@(posedge clock);
		if (c == 0) mean_current_value <= doze_current_limit + 16'd1
			+ 16'($urandom_range(255));
		if (c == 1) wake_cmp <= 1'b1;
		if (c == 2) host.wake(1'b1);
		wait_mode(FGPM_NORMAL, 10);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(58482));
		// levels drawn so that random targets straddle both thresholds
		init_charge <= 16'(201 + $urandom_range(99));
		low_charge_set_level <= 16'(80 + $urandom_range(40));
		low_charge_clear_level <= 16'(160 + $urandom_range(40));
		doze_current_limit <= 16'(256 + $urandom_range(255));
		deep_current_limit <= 16'(64 + $urandom_range(127));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk_bit("hf_osc_en", 1'b1, hf_osc_en);
		hold_mode(FGPM_WAIT, 20);
		@(posedge clock);
		cell_detect <= 1'b1;
		bring_up();
		repeat (2) @(negedge clock);
		exp_rem = init_charge;
		exp_low = 1'b0;
		chk("remaining", exp_rem, remaining_charge_value);
		strobes(10, n);
		chk("normal strobes", 16'd10, 16'(n));
		// corner targets first: at set level, just below, at clear, above
		for (int i = 0; i < 24; i++) begin
			tgt = (i < 4) ? low_charge_set_level - 16'(i == 1) : 16'd0;
			if (i >= 2) tgt = low_charge_clear_level + 16'(i == 3);
			if (i >= 4) tgt = 16'(50 + $urandom_range(200));
			@(posedge clock);
			sample_strobe <= 1'b1;
			charge_delta <= tgt - exp_rem;
			@(posedge clock);
			sample_strobe <= 1'b0;
			exp_rem = tgt;
			exp_low = exp_flag(exp_low, tgt);
			repeat (3) @(negedge clock);
			chk("remaining", exp_rem, remaining_charge_value);
			chk_bit("low flag", exp_low, low_charge_flag);
		end
		for (int i = 0; i < 6; i++) begin
			est = 8'($urandom);
			tgt = 16'h0C00 + 16'($urandom_range(1023));
			@(posedge clock);
			soc_estimate <= est;
			cell_voltage <= tgt;
			// one below, at, and one above the cell voltage
			terminate_voltage <= tgt + 16'(i % 3) - 16'd1;
			repeat (3) @(negedge clock);
			chk("soc", 16'(exp_soc(est, cell_voltage, terminate_voltage)),
				16'(soc_value));
		end
		@(posedge clock);
		operation_config <= 8'h01;
		cell_voltage <= 16'h0E00;
		wait_mode(FGPM_CAL, 10);
		chk_bit("cal_active", 1'b1, cal_active);
		exit_by(1);
		for (int c = 0; c < 2; c++) begin
			@(posedge clock);
			wake_cmp <= 1'b0;
			mean_current_value <= 16'h0010;
			wait_mode(FGPM_CAL, 10);
			n = 0;
			while (cal_active === 1'b1 && n < 40) begin
				@(negedge clock);
				n++;
			end
			chk("cal cycles", 16'(CAL_CYCLES), 16'(n));
			chk("power_mode", 16'(FGPM_DOZE), 16'(power_mode));
			chk_bit("hf_osc_en", 1'b0, hf_osc_en);
			strobes(80, n);
			chk("doze strobes", 16'd2, 16'(n));
			exit_by(c);
		end
		@(posedge clock);
		operation_config <= 8'h00;
		light_doze_allow <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			host.wake(1'b0);
			wake_cmp <= 1'b0;
			mean_current_value <= 16'h0010;
			wait_mode(FGPM_LDOZE, 10);
			chk_bit("hf_osc_en", 1'b1, hf_osc_en);
			exit_by(c);
		end
		@(posedge clock);
		light_doze_allow <= 1'b0;
		wake_cmp <= 1'b0;
		mean_current_value <= 16'hFE00;
		host.wake(1'b0);
		host.request_deep(1'b1);
		hold_mode(FGPM_NORMAL, 20);
		@(posedge clock);
		mean_current_value <= 16'hFFF0;
		wait_mode(FGPM_DEEP, 10);
		chk_bit("ocv_valid", 1'b1, ocv_valid);
		@(posedge clock);
		wake_cmp <= 1'b1;
		mean_current_value <= 16'h0400;
		host.command(1'b1);
		hold_mode(FGPM_DEEP, 50);
		host.command(1'b0);
		host.request_deep(1'b0);
		wake_cmp <= 1'b0;
		mean_current_value <= 16'h0010;
		host.wake(1'b1);
		bring_up();
		host.wake(1'b0);
		// synchronised wake level must fall before deep idle is re-entered
		repeat (3) @(posedge clock);
		deep_voltage_limit <= 16'h0F00;
		wait_mode(FGPM_DEEP, 10);
		hold_mode(FGPM_DEEP, 20);
		@(posedge clock);
		deep_voltage_limit <= 16'h0C00;
		host.wake(1'b1);
		bring_up();
		host.wake(1'b0);
		cell_detect <= 1'b0;
		wait_mode(FGPM_WAIT, 10);
		chk_bit("present", 1'b0, battery_present_flag);
		// remaining value follows the mode one cycle later
		@(negedge clock);
		chk("remaining", 16'h0000, remaining_charge_value);
		hold_mode(FGPM_WAIT, 20);
		host.command(1'b1);
		n = 0;
		repeat (10) begin
			@(negedge clock);
			if (cmd_service === 1'b1) n++;
		end
		chk_bit("cmd_service", 1'b1, n > 0);
		host.command(1'b0);
		hold_mode(FGPM_WAIT, 20);
		end_of_test();
	end
endmodule

/* File: logic/fgpm_charge_acc.sv */
// signed coulomb accumulator for the remaining charge value
`timescale 1ns/100ps
module fgpm_charge_acc #(
	parameter int W = 16
) (
	input wire logic clock, // system clock
	input wire logic rst, // sync reset
	input wire logic load, // load initial value
	input wire logic [W-1:0] load_value, // initial charge
	input wire logic step, // accumulate one sample
	input wire logic signed [W-1:0] delta, // signed charge sample
	output logic [W-1:0] charge // accumulated charge
);
	import fgpm_pkg::*;
	logic [W-1:0] charge_reg;
	logic [W-1:0] charge_next;
	logic signed [W:0] sum;

	always_comb begin
		sum = $signed({1'b0, charge_reg}) + (W+1)'(delta);
		charge_next = charge_reg;
		if (load) begin
			charge_next = load_value;
		end else if (step) begin
			// saturate instead of wrapping at either end
			if (sum[W]) begin
				charge_next = (delta < 0) ? '0 : '1;
			end else begin
				charge_next = sum[W-1:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			charge_reg <= '0;
		end else begin
			charge_reg <= charge_next;
		end
	end

	assign charge = charge_reg;
endmodule

/* File: logic/fgpm_sync.sv */
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module fgpm_sync #(
	parameter int N = 1
) (
	input wire logic clock, // system clock
	input wire logic rst, // sync reset
	input wire logic [N-1:0] d, // asynchronous levels
	output logic [N-1:0] q // synchronised levels
);
	logic [N-1:0] s1_reg;
	logic [N-1:0] s2_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
		end
	end

	assign q = s2_reg;
endmodule

/* File: logic/fgpm_top.sv */
// power-mode sequencer and low-charge flags of the fuel gauge
// Summary of operation
// - remaining charge follows accumulated sense charge while charging or discharging
// - low-charge flag sets when remaining charge drops below set level
// - low-charge flag clears only when charge rises above clear level
// - reported charge state forced to zero at terminate voltage
// - with no cell present the block halts in battery-wait mode
// - cell insertion: measure open-circuit voltage, set present flag, pick profile
// - host commands are serviced in battery-wait mode, then it halts again
// - normal mode applies when no other does; measures and updates data
// - doze entered when doze allowed and mean current below doze limit
// - offset calibration runs after doze qualifies, before entering doze
// - doze stops fast oscillator and updates data only periodically
// - doze left on mean current above limit or wake comparator
// - cell removal stops gauging and returns to battery-wait mode, except in deep idle
// - light doze entered when allowed and current below limit, both oscillators on
// - light doze left on addressed bus traffic, high current or wake
// - requested deep idle waits for valid voltage and small mean current
// - deep idle also entered on low cell voltage with valid voltage
// - deep idle held until addressed transaction or power-on reset
// - traffic for other bus targets does not wake deep idle
`timescale 1ns/100ps
module fgpm_top (
	input wire logic clock, // 40 MHz system clock
	input wire logic rst, // sync reset, active high
	input wire logic cell_detect, // cell present pin
	input wire logic ext_power, // external supply present pin
	input wire logic wake_cmp, // sense current above wake level
	input wire logic addr_hit, // addressed bus transaction seen
	input wire logic cmd_pending, // host command waiting
	input wire logic [fgpm_pkg::CUR_W-1:0] mean_current_value, // signed
	input wire logic [fgpm_pkg::VOLT_W-1:0] cell_voltage, // cell volts
	input wire logic signed [fgpm_pkg::CAP_W-1:0] charge_delta, // per sample
	input wire logic sample_strobe, // new charge sample
	input wire logic [fgpm_pkg::CAP_W-1:0] init_charge, // from profile
	input wire logic [fgpm_pkg::SOC_W-1:0] soc_estimate, // computed soc
	input wire logic ocv_done, // voltage measurement finished
	input wire logic [7:0] operation_config, // config byte
	input wire logic light_doze_allow, // light doze enable
	input wire logic deep_idle_req, // host deep-idle request
	input wire logic [fgpm_pkg::CAP_W-1:0] low_charge_set_level, // set level
	input wire logic [fgpm_pkg::CAP_W-1:0] low_charge_clear_level, // clear
	input wire logic [fgpm_pkg::CUR_W-1:0] doze_current_limit, // doze limit
	input wire logic [fgpm_pkg::CUR_W-1:0] deep_current_limit, // idle limit
	input wire logic [fgpm_pkg::VOLT_W-1:0] deep_voltage_limit, // idle volts
	input wire logic [fgpm_pkg::VOLT_W-1:0] terminate_voltage, // empty volts
	output logic [2:0] power_mode, // current mode code
	output logic hf_osc_en, // fast oscillator enable
	output logic battery_present_flag, // cell detected
	output logic low_charge_flag, // low charge warning
	output logic [fgpm_pkg::CAP_W-1:0] remaining_charge_value, // charge
	output logic [fgpm_pkg::SOC_W-1:0] soc_value, // reported soc
	output logic ocv_start, // start voltage measurement pulse
	output logic profile_select, // select profile pulse
	output logic cal_active, // offset calibration running
	output logic measure_strobe, // measurement/update pulse
	output logic cmd_service, // host command serviced pulse
	output logic ocv_valid // valid voltage measurement held
);
	import fgpm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic cell_s, ext_s, wake_s, hit_s, cmd_s;
	fgpm_sync #(.N(5)) u_sync (
		.clock(clock),
		.rst(rst),
		.d({cell_detect, ext_power, wake_cmp, addr_hit, cmd_pending}),
		.q({cell_s, ext_s, wake_s, hit_s, cmd_s})
	);

	logic [CAP_W-1:0] charge;
	logic acc_load;
	logic gauging;
	fgpm_charge_acc #(.W(CAP_W)) u_acc (
		.clock(clock),
		.rst(rst),
		.load(acc_load),
		.load_value(init_charge),
		.step(sample_strobe && gauging),
		.delta(charge_delta),
		.charge(charge)
	);

	////////////////////////////////////////////////////////////////////////
	fgpm_mode_t mode_reg, mode_next;
	logic [7:0] cnt_reg, cnt_next;
	logic present_reg, present_next;
	logic ocv_reg, ocv_next;
	logic low_reg, low_next;
	logic [SOC_W-1:0] soc_reg, soc_next;
	logic [CAP_W-1:0] rem_reg, rem_next;
	logic ocv_start_reg, ocv_start_next;
	logic prof_reg, prof_next;
	logic meas_reg, meas_next;
	logic svc_reg, svc_next;
	logic signed [CUR_W-1:0] cur;
	logic [CUR_W-1:0] cur_mag;
	logic below_doze, deep_ok, removed, period_end;

	always_comb begin
		cur = $signed(mean_current_value);
		cur_mag = cur[CUR_W-1] ? CUR_W'(-cur) : mean_current_value;
		// magnitude used: charging current also blocks doze
		below_doze = cur_mag < doze_current_limit;
		deep_ok = ocv_reg && ((deep_idle_req
			&& cur_mag < deep_current_limit)
			|| cell_voltage < deep_voltage_limit);
		removed = !cell_s;
		period_end = cnt_reg == PERIOD_LAST;
		gauging = mode_reg != FGPM_WAIT && mode_reg != FGPM_INIT;
	end

	always_comb begin
		mode_next = mode_reg;
		cnt_next = cnt_reg;
		present_next = present_reg;
		ocv_next = ocv_reg;
		ocv_start_next = 1'b0;
		prof_next = 1'b0;
		meas_next = 1'b0;
		svc_next = 1'b0;
		acc_load = 1'b0;
		unique case (mode_reg)
			FGPM_WAIT: begin
				// halted until a cell appears
				present_next = 1'b0;
				ocv_next = 1'b0;
				svc_next = cmd_s && !svc_reg;
				if (cell_s) begin
					mode_next = FGPM_INIT;
					ocv_start_next = 1'b1;
				end
			end
			FGPM_INIT: begin
				if (removed) begin
					mode_next = FGPM_WAIT;
				end else if (ocv_done) begin
					ocv_next = 1'b1;
					present_next = 1'b1;
					prof_next = 1'b1;
					acc_load = 1'b1;
					mode_next = FGPM_NORMAL;
				end
			end
			FGPM_NORMAL: begin
				cnt_next = period_end ? CNT_ZERO : cnt_reg + CNT_ONE;
				meas_next = 1'b1;
				if (deep_ok) begin
					mode_next = FGPM_DEEP;
				end else if (operation_config[OP_DOZE_BIT]
					&& below_doze && !wake_s) begin
					mode_next = FGPM_CAL;
					cnt_next = CNT_ZERO;
				end else if (light_doze_allow && below_doze
					&& !wake_s) begin
					mode_next = FGPM_LDOZE;
					cnt_next = CNT_ZERO;
				end
			end
			FGPM_CAL: begin
				cnt_next = cnt_reg + CNT_ONE;
				if (!below_doze || wake_s) begin
					mode_next = FGPM_NORMAL;
				end else if (cnt_reg == CAL_LAST) begin
					mode_next = FGPM_DOZE;
					cnt_next = CNT_ZERO;
				end
			end
			FGPM_DOZE, FGPM_LDOZE: begin
				cnt_next = period_end ? CNT_ZERO : cnt_reg + CNT_ONE;
				meas_next = period_end;
				if (!below_doze || wake_s) begin
					mode_next = FGPM_NORMAL;
				end else if (mode_reg == FGPM_LDOZE && hit_s) begin
					mode_next = FGPM_NORMAL;
				end else if (deep_ok) begin
					mode_next = FGPM_DEEP;
				end
			end
			FGPM_DEEP: begin
				// only an addressed transaction wakes
				if (hit_s) begin
					mode_next = FGPM_INIT;
					ocv_next = 1'b0;
					ocv_start_next = 1'b1;
				end
			end
			default: begin
				mode_next = FGPM_WAIT;
			end
		endcase
		// removal ends gauging in every mode except deep idle, with or without charger
		if (removed && mode_reg != FGPM_WAIT && mode_reg != FGPM_DEEP) begin
			mode_next = FGPM_WAIT;
			present_next = 1'b0;
			ocv_start_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mode_reg <= FGPM_WAIT;
			cnt_reg <= CNT_ZERO;
			present_reg <= 1'b0;
			ocv_reg <= 1'b0;
			ocv_start_reg <= 1'b0;
			prof_reg <= 1'b0;
			meas_reg <= 1'b0;
			svc_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			cnt_reg <= cnt_next;
			present_reg <= present_next;
			ocv_reg <= ocv_next;
			ocv_start_reg <= ocv_start_next;
			prof_reg <= prof_next;
			meas_reg <= meas_next;
			svc_reg <= svc_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		low_next = low_reg;
		if (charge < low_charge_set_level) begin
			low_next = 1'b1;
		end else if (charge > low_charge_clear_level) begin
			low_next = 1'b0;
		end
		rem_next = gauging ? charge : CAP_RESET;
		soc_next = (cell_voltage <= terminate_voltage) ? SOC_EMPTY
			: soc_estimate;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			low_reg <= 1'b0;
			rem_reg <= CAP_RESET;
			soc_reg <= SOC_EMPTY;
		end else begin
			low_reg <= low_next;
			rem_reg <= rem_next;
			soc_reg <= soc_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic hf_reg, cal_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			hf_reg <= 1'b1;
			cal_reg <= 1'b0;
		end else begin
			hf_reg <= mode_next != FGPM_DOZE;
			cal_reg <= mode_next == FGPM_CAL;
		end
	end

	assign power_mode = mode_reg;
	assign hf_osc_en = hf_reg;
	assign battery_present_flag = present_reg;
	assign low_charge_flag = low_reg;
	assign remaining_charge_value = rem_reg;
	assign soc_value = soc_reg;
	assign ocv_start = ocv_start_reg;
	assign profile_select = prof_reg;
	assign cal_active = cal_reg;
	assign measure_strobe = meas_reg;
	assign cmd_service = svc_reg;
	assign ocv_valid = ocv_reg;

	////////////////////////////////////////////////////////////////////////
	property p_low_set;
		@(posedge clock) disable iff (rst)
		charge < low_charge_set_level |=> low_charge_flag;
	endproperty
	a_low_set: assert property (p_low_set) else $error("low flag not set");

	property p_low_hold;
		@(posedge clock) disable iff (rst)
		low_charge_flag && charge <= low_charge_clear_level |=> low_charge_flag;
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low flag dropped");

	property p_soc_zero;
		@(posedge clock) disable iff (rst)
		cell_voltage <= terminate_voltage |=> soc_value == SOC_EMPTY;
	endproperty
	a_soc_zero: assert property (p_soc_zero) else $error("soc not zero");

	property p_cal_before_doze;
		@(posedge clock) disable iff (rst)
		mode_reg != FGPM_DOZE ##1 mode_reg == FGPM_DOZE
		|-> $past(mode_reg) == FGPM_CAL;
	endproperty
	a_cal_before_doze: assert property (p_cal_before_doze)
		else $error("doze without calibration");

	property p_doze_hf;
		@(posedge clock) disable iff (rst)
		mode_reg == FGPM_DOZE |-> !hf_osc_en;
	endproperty
	a_doze_hf: assert property (p_doze_hf) else $error("hf on in doze");

	property p_deep_entry;
		@(posedge clock) disable iff (rst)
		mode_reg != FGPM_DEEP ##1 mode_reg == FGPM_DEEP |-> $past(ocv_valid);
	endproperty
	a_deep_entry: assert property (p_deep_entry)
		else $error("deep idle without valid ocv");

	property p_deep_hold;
		@(posedge clock) disable iff (rst)
		mode_reg == FGPM_DEEP && !hit_s |=> mode_reg == FGPM_DEEP;
	endproperty
	a_deep_hold: assert property (p_deep_hold) else $error("deep idle left");

	property p_remove;
		@(posedge clock) disable iff (rst)
		!cell_s && mode_reg == FGPM_NORMAL
		|=> mode_reg == FGPM_WAIT && !battery_present_flag;
	endproperty
	a_remove: assert property (p_remove) else $error("removal missed");

	property p_insert;
		@(posedge clock) disable iff (rst)
		mode_reg == FGPM_INIT && ocv_done && cell_s
		|=> battery_present_flag && profile_select;
	endproperty
	a_insert: assert property (p_insert) else $error("insert init missed");
endmodule

/* File: pkg/fgpm_pkg.sv */
// constants and types for the fuel gauge power-mode sequencer
package fgpm_pkg;
	localparam int CAP_W = 16;
	localparam int CUR_W = 16;
	localparam int VOLT_W = 16;
	localparam int SOC_W = 8;
	localparam logic [SOC_W-1:0] SOC_EMPTY = 8'h00;
	localparam logic [CAP_W-1:0] CAP_RESET = 16'h0000;
	localparam logic [CUR_W-1:0] CUR_ZERO = 16'h0000;
	localparam int OP_DOZE_BIT = 0;
	localparam int CAL_CYCLES = 16;
	localparam int PERIOD_CYCLES = 40;
	localparam logic [7:0] CAL_LAST = 8'(CAL_CYCLES - 1);
	localparam logic [7:0] PERIOD_LAST = 8'(PERIOD_CYCLES - 1);
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	typedef enum logic [2:0] {
		FGPM_WAIT = 3'b000,
		FGPM_INIT = 3'b001,
		FGPM_NORMAL = 3'b010,
		FGPM_CAL = 3'b011,
		FGPM_DOZE = 3'b100,
		FGPM_LDOZE = 3'b101,
		FGPM_DEEP = 3'b110
	} fgpm_mode_t;
endpackage
